// file: design/vwsp_pkg.sv
// Shared constants and types for the variable width slave port.
package vwsp_pkg;
	localparam int VWSP_LINES = 8;
	localparam int VWSP_CMD_BITS = 7;
	localparam int VWSP_BYTE_BITS = 8;
	localparam logic [3:0] VWSP_CMD_WRITE_DEF = 4'h1;
	localparam logic [3:0] VWSP_CMD_READ_DEF = 4'h2;
	localparam logic VWSP_ACK = 1'b0;
	localparam logic VWSP_NAK = 1'b1;

	typedef enum logic [1:0] {
		VWSP_W1,
		VWSP_W2,
		VWSP_W4,
		VWSP_W8
	} vwsp_width_e;

	typedef enum logic [2:0] {
		VWSP_IDLE,
		VWSP_CMD,
		VWSP_TURN,
		VWSP_DATA,
		VWSP_HOLD
	} vwsp_state_e;

	typedef struct packed {
		logic [VWSP_LINES-1:0] data_out;
		logic [VWSP_LINES-1:0] data_oe_n;
		logic miso_out;
		logic miso_oe_n;
	} vwsp_pins_s;

	typedef struct packed {
		logic sclk_q1;
		logic sclk_q2;
		logic sclk_q3;
		logic ss_n_q1;
		logic ss_n_q2;
		logic [VWSP_LINES-1:0] data_q1;
		logic [VWSP_LINES-1:0] data_q2;
	} vwsp_sync_s;
endpackage

// file: design/vwsp_sync.sv
// Two-stage input synchroniser for the link pins with clock edge detect.
`timescale 1ns/10ps
`default_nettype none
module vwsp_sync
	import vwsp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic [VWSP_LINES-1:0] data_in,
	output logic sclk_rise,
	output logic ss_n_sync,
	output logic [VWSP_LINES-1:0] data_sync
);
	vwsp_sync_s state_reg;
	vwsp_sync_s state_next;

	always_comb begin
		state_next = state_reg;
		state_next.sclk_q1 = sclk;
		state_next.sclk_q2 = state_reg.sclk_q1;
		state_next.sclk_q3 = state_reg.sclk_q2;
		state_next.ss_n_q1 = ss_n;
		state_next.ss_n_q2 = state_reg.ss_n_q1;
		state_next.data_q1 = data_in;
		state_next.data_q2 = state_reg.data_q1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= '{sclk_q1: 1'b0, sclk_q2: 1'b0, sclk_q3: 1'b0,
				ss_n_q1: 1'b1, ss_n_q2: 1'b1,
				data_q1: {VWSP_LINES{1'b1}}, data_q2: {VWSP_LINES{1'b1}}};
		end else begin
			state_reg <= state_next;
		end
	end

	assign sclk_rise = state_reg.sclk_q2 & ~state_reg.sclk_q3;
	assign ss_n_sync = state_reg.ss_n_q2;
	assign data_sync = state_reg.data_q2;
endmodule
`default_nettype wire

// file: design/vwsp_port.sv
// Variable width slave port: command, width decode and 1-bit data phase.
// Notes on behaviour
// RULE1: Slave on half-duplex 1/2/4/8 bit bus; here the width is only decoded and data moves on line0 alone.
// RULE2: Deselected: line0 write status, MISO read status.
// RULE3: Option disables status drive when deselected.
// RULE4: Select starts command/width phase, then data.
// RULE5: ACK or NAK driven on MISO per byte.
// RULE6: Master stops on NAK by deselecting.
// RULE7: Width and command sampled first edge, all lines.
// RULE8: Priority width decode from lines 7..1.
// RULE9: Undriven lines pulled up, read as one.
// RULE10: Command bits at positions 0,3,5,6.
// RULE11: Release line0 immediately on select.
// RULE12: Command over 7 clocks, 8th is turnaround.
// RULE13: 1-bit byte takes 8 clocks on line0.
// RULE14: MISO status valid whole data phase.
// RULE15: Master releases line0 before deselect on write.
// RULE16: After read, status resumes on deselect directly.
// RULE17: Data phase runs only while selected.
// RULE18: NAK on full write or empty read.
`timescale 1ns/10ps
`default_nettype none
module vwsp_port
	import vwsp_pkg::*;
#(
	parameter logic [3:0] CMD_WRITE = VWSP_CMD_WRITE_DEF,
	parameter logic [3:0] CMD_READ = VWSP_CMD_READ_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic [VWSP_LINES-1:0] data_in,
	output logic [VWSP_LINES-1:0] data_out,
	output logic [VWSP_LINES-1:0] data_oe_n,
	output logic miso_out,
	output logic miso_oe_n,
	input wire logic status_enable,
	input wire logic wr_buf_full,
	input wire logic rd_buf_empty,
	output logic [VWSP_BYTE_BITS-1:0] wr_data,
	output logic wr_valid,
	input wire logic [VWSP_BYTE_BITS-1:0] rd_data,
	output logic rd_taken,
	output logic [3:0] cmd_code,
	output logic [1:0] bus_width,
	output logic cmd_valid
);
	typedef struct packed {
		vwsp_state_e st;
		logic [2:0] cnt;
		logic [3:0] cmd;
		vwsp_width_e width;
		logic is_write;
		logic is_read;
		logic nak;
		logic [VWSP_BYTE_BITS-1:0] shift;
		logic [VWSP_BYTE_BITS-1:0] wdata;
		logic wvalid;
		logic rtaken;
		logic cvalid;
		vwsp_pins_s pins;
	} vwsp_core_s;

	vwsp_core_s state_reg;
	vwsp_core_s state_next;
	logic sclk_rise;
	logic ss_n_s;
	logic [VWSP_LINES-1:0] data_s;
	logic [3:0] cmd_smp;
	vwsp_width_e width_smp;

	// Link pins are asynchronous to clk; sampled through two flops.
	vwsp_sync u_sync (
		.clk(clk),
		.rst(rst),
		.sclk(sclk),
		.ss_n(ss_n),
		.data_in(data_in),
		.sclk_rise(sclk_rise),
		.ss_n_sync(ss_n_s),
		.data_sync(data_s)
	);

	// RULE10: command bit map
	assign cmd_smp = {data_s[0], data_s[3], data_s[5], data_s[6]};

	// RULE8: priority width decode
	// RULE9: undriven lines read high
	always_comb begin
		if (~&data_s[7:4]) begin
			width_smp = VWSP_W8;
		end else if (~&data_s[3:2]) begin
			width_smp = VWSP_W4;
		end else if (!data_s[1]) begin
			width_smp = VWSP_W2;
		end else begin
			width_smp = VWSP_W1;
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.wvalid = 1'b0;
		state_next.rtaken = 1'b0;
		state_next.cvalid = 1'b0;
		state_next.pins.data_out = {VWSP_LINES{1'b1}};
		state_next.pins.data_oe_n = {VWSP_LINES{1'b1}};
		state_next.pins.miso_out = 1'b1;
		state_next.pins.miso_oe_n = 1'b1;
		if (ss_n_s) begin
			// RULE17: deselect ends any phase
			state_next.st = VWSP_IDLE;
			state_next.cnt = 3'd0;
			// RULE2: status drive while idle
			// RULE3: option gates the drive
			// RULE16: status resumes after read
			if (status_enable) begin
				state_next.pins.data_out[0] = wr_buf_full;
				state_next.pins.data_oe_n[0] = 1'b0;
				state_next.pins.miso_out = rd_buf_empty;
				state_next.pins.miso_oe_n = 1'b0;
			end
		end else begin
			// RULE11: line0 released at select
			unique case (state_reg.st)
				VWSP_IDLE: begin
					state_next.st = VWSP_CMD;
				end
				VWSP_CMD: begin
					// RULE7: sample all lines first edge
					// RULE4: command phase first
					if (sclk_rise) begin
						if (state_reg.cnt == 3'd0) begin
							state_next.cmd = cmd_smp;
							state_next.width = width_smp;
							state_next.is_write = (cmd_smp == CMD_WRITE);
							state_next.is_read = (cmd_smp == CMD_READ);
							state_next.cvalid = 1'b1;
						end
						// RULE12: seven command clocks
						if (state_reg.cnt == 3'(VWSP_CMD_BITS - 1)) begin
							state_next.st = VWSP_TURN;
							state_next.cnt = 3'd0;
						end else begin
							state_next.cnt = state_reg.cnt + 3'd1;
						end
					end
				end
				VWSP_TURN: begin
					// RULE12: eighth clock turnaround
					if (sclk_rise) begin
						state_next.st = VWSP_DATA;
						state_next.cnt = 3'd0;
						// RULE18: NAK on full or empty
						state_next.nak = (state_reg.is_write && wr_buf_full) ||
							(state_reg.is_read && rd_buf_empty) ||
							!(state_reg.is_write || state_reg.is_read);
						state_next.shift = rd_data;
						state_next.rtaken = state_reg.is_read && !rd_buf_empty;
					end
				end
				VWSP_DATA: begin
					// RULE13: eight clocks per byte
					if (sclk_rise) begin
						if (state_reg.is_write) begin
							state_next.shift = {state_reg.shift[6:0], data_s[0]};
						end else begin
							state_next.shift = {state_reg.shift[6:0], 1'b0};
						end
						if (state_reg.cnt == 3'(VWSP_BYTE_BITS - 1)) begin
							state_next.cnt = 3'd0;
							if (state_reg.is_write && !state_reg.nak) begin
								state_next.wdata = {state_reg.shift[6:0], data_s[0]};
								state_next.wvalid = 1'b1;
							end
							// Next byte status; reads reload from the buffer.
							state_next.nak = (state_reg.is_write && wr_buf_full) ||
								(state_reg.is_read && rd_buf_empty) || state_reg.nak;
							if (state_reg.is_read) begin
								state_next.shift = rd_data;
								state_next.rtaken = !rd_buf_empty && !state_reg.nak;
							end
						end else begin
							state_next.cnt = state_reg.cnt + 3'd1;
						end
					end
				end
				VWSP_HOLD: begin
					state_next.st = VWSP_HOLD;
				end
			endcase
			if (state_next.st == VWSP_DATA) begin
				// RULE5: ACK or NAK per byte
				// RULE14: held for whole data phase
				state_next.pins.miso_out = state_next.nak ? VWSP_NAK : VWSP_ACK;
				state_next.pins.miso_oe_n = 1'b0;
				// RULE1: device drives line0 on reads
				if (state_reg.is_read && !state_next.nak) begin
					state_next.pins.data_out[0] = state_next.shift[7];
					state_next.pins.data_oe_n[0] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= '{st: VWSP_IDLE, cnt: 3'd0, cmd: 4'h0,
				width: VWSP_W1, is_write: 1'b0, is_read: 1'b0, nak: 1'b0,
				shift: 8'h00, wdata: 8'h00, wvalid: 1'b0, rtaken: 1'b0,
				cvalid: 1'b0, pins: '{data_out: 8'hFF, data_oe_n: 8'hFF,
				miso_out: 1'b1, miso_oe_n: 1'b1}};
		end else begin
			state_reg <= state_next;
		end
	end

	assign data_out = state_reg.pins.data_out;
	assign data_oe_n = state_reg.pins.data_oe_n;
	assign miso_out = state_reg.pins.miso_out;
	assign miso_oe_n = state_reg.pins.miso_oe_n;
	assign wr_data = state_reg.wdata;
	assign wr_valid = state_reg.wvalid;
	assign rd_taken = state_reg.rtaken;
	assign cmd_code = state_reg.cmd;
	assign bus_width = state_reg.width;
	assign cmd_valid = state_reg.cvalid;
endmodule
`default_nettype wire

// file: verification/vwsp_port_asserts.sv
// Pin level checker for the slave port, bound to every port instance.
`timescale 1ns/10ps
`default_nettype none
module vwsp_port_asserts
	import vwsp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ss_n,
	input wire logic [VWSP_LINES-1:0] data_out,
	input wire logic [VWSP_LINES-1:0] data_oe_n,
	input wire logic miso_out,
	input wire logic miso_oe_n,
	input wire logic status_enable,
	input wire logic wr_buf_full,
	input wire logic rd_buf_empty,
	input wire logic wr_valid,
	input wire logic rd_taken,
	input wire logic cmd_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_status_on;
		(ss_n && status_enable && $stable(wr_buf_full)
			&& $stable(rd_buf_empty))[*6] |-> !data_oe_n[0] && !miso_oe_n
			&& data_out[0] == wr_buf_full && miso_out == rd_buf_empty;
	endproperty
	a_status_on: assert property (p_status_on)
		else $error("status not shown while deselected");
	property p_status_off;
		(!status_enable && ss_n)[*4] |-> data_oe_n[0] && miso_oe_n;
	endproperty
	a_status_off: assert property (p_status_off)
		else $error("status driven while switched off");
	property p_release;
		$fell(ss_n) |-> ##[0:3] data_oe_n[0];
	endproperty
	a_release: assert property (p_release)
		else $error("line 0 not released on select");
	property p_upper;
		data_oe_n[7:1] == 7'h7f;
	endproperty
	a_upper: assert property (p_upper)
		else $error("upper data line driven");
	property p_cmd_once;
		cmd_valid |=> !cmd_valid [*8];
	endproperty
	a_cmd_once: assert property (p_cmd_once)
		else $error("command captured twice");
	property p_rd_ack;
		rd_taken |-> ##[0:1] (!miso_oe_n && miso_out == VWSP_ACK);
	endproperty
	a_rd_ack: assert property (p_rd_ack)
		else $error("read byte taken without ack");
	property p_wr_ack;
		wr_valid |-> !$past(miso_oe_n) && $past(miso_out) == VWSP_ACK;
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("write byte stored without ack");
	property p_wr_sel;
		wr_valid |-> !$past(ss_n, 5);
	endproperty
	a_wr_sel: assert property (p_wr_sel)
		else $error("write byte outside selection");
endmodule
bind vwsp_port vwsp_port_asserts u_chk (
	.clk(clk),
	.rst(rst),
	.ss_n(ss_n),
	.data_out(data_out),
	.data_oe_n(data_oe_n),
	.miso_out(miso_out),
	.miso_oe_n(miso_oe_n),
	.status_enable(status_enable),
	.wr_buf_full(wr_buf_full),
	.rd_buf_empty(rd_buf_empty),
	.wr_valid(wr_valid),
	.rd_taken(rd_taken),
	.cmd_valid(cmd_valid)
);
`default_nettype wire

// file: verification/vwsp_master.sv
// Link master model: select, link clock and the pulled-up data lines.
`timescale 1ns/10ps
`default_nettype none
module vwsp_master
	import vwsp_pkg::*;
(
	input wire logic clk,
	output logic sclk,
	output logic ss_n,
	input wire logic [VWSP_LINES-1:0] data_out,
	input wire logic [VWSP_LINES-1:0] data_oe_n,
	output logic [VWSP_LINES-1:0] data_in,
	input wire logic miso_out,
	input wire logic miso_oe_n
);
	logic [VWSP_LINES-1:0] m_val = 8'hff;
	logic [VWSP_LINES-1:0] m_en = 8'h00;
	logic miso;
	assign data_in = (~data_oe_n & data_out) | (data_oe_n & (~m_en | m_val));
	// A released line has no pull; miso_out is 1 whenever released, so show its inverse, 0.
	assign miso = miso_out ^ miso_oe_n;
	initial begin
		sclk = 1'b0;
		ss_n = 1'b1;
	end
	task automatic half();
		repeat (4) @(posedge clk);
	endtask
	task automatic tick(input logic [7:0] v, e, output logic [1:0] s);
		m_val <= v;
		m_en <= e;
		repeat (3) @(posedge clk);
		@(negedge clk);
		s = {miso, data_in[0]};
		@(posedge clk);
		sclk <= 1'b1;
		half();
		sclk <= 1'b0;
	endtask
	task automatic frame(input logic [7:0] w, c, input logic wr,
		input logic [15:0] wd, input int nb,
		output logic [15:0] rd, output logic [1:0] nk);
		logic [1:0] s;
		logic [7:0] f;
		// command on lines 0, 3, 5, 6 and width on the rest.
		f = (c & 8'h69) | (w & 8'h96);
		rd = 16'h0000;
		nk = 2'b00;
		ss_n <= 1'b0;
		// line 0 stays free for half a link clock after select
		half();
		for (int k = 0; k < 8; k++) begin
			tick(k == 0 ? f : {7'h7f, c[k]},
				k == 0 ? {~f[7:1], 1'b1} : {7'h00, k < 7}, s);
		end
		// eight edges per byte, status sampled on each
		for (int b = 0; b < nb; b++) begin
			for (int k = 7; k >= 0; k--) begin
				tick({7'h7f, wd[8*b+k]}, {7'h00, wr}, s);
				rd[8*b+k] = s[0];
				nk[b] = nk[b] | s[1];
				// abort at once on a refusal
				if (k == 7 && nk[b]) break;
			end
			if (nk[b]) break;
		end
		m_en <= 8'h00;
		half();
		ss_n <= 1'b1;
		half();
	endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the variable width slave port.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import vwsp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic status_enable = 1'b1;
	logic wr_buf_full = 1'b0;
	logic rd_buf_empty = 1'b0;
	logic [7:0] rd_data = 8'h00;
	wire logic sclk, ss_n, miso_out, miso_oe_n;
	wire logic wr_valid, rd_taken, cmd_valid;
	wire logic [7:0] data_in, data_out, data_oe_n, wr_data;
	wire logic [3:0] cmd_code;
	wire logic [1:0] bus_width;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	int nwr = 0;
	logic [15:0] rd;
	logic [1:0] nk;
	logic [7:0] w, c, seen_wr;
	vwsp_port uut (
		.clk(clk),
		.rst(rst),
		.sclk(sclk),
		.ss_n(ss_n),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe_n(data_oe_n),
		.miso_out(miso_out),
		.miso_oe_n(miso_oe_n),
		.status_enable(status_enable),
		.wr_buf_full(wr_buf_full),
		.rd_buf_empty(rd_buf_empty),
		.wr_data(wr_data),
		.wr_valid(wr_valid),
		.rd_data(rd_data),
		.rd_taken(rd_taken),
		.cmd_code(cmd_code),
		.bus_width(bus_width),
		.cmd_valid(cmd_valid)
	);
	vwsp_master mst (
		.clk(clk),
		.sclk(sclk),
		.ss_n(ss_n),
		.data_out(data_out),
		.data_oe_n(data_oe_n),
		.data_in(data_in),
		.miso_out(miso_out),
		.miso_oe_n(miso_oe_n)
	);
	initial forever #5 clk = ~clk;
	task automatic check(input string what, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [1:0] wexp(input logic [7:0] p);
		if (p[7:4] != 4'hf) return 2'h3;
		if (p[3:2] != 2'h3) return 2'h2;
		return p[1] ? 2'h0 : 2'h1;
	endfunction
	function automatic logic [7:0] cbyte(input logic [3:0] k, logic [7:0] r);
		return {r[7], k[0], k[1], r[4], k[2], r[2:1], k[3]};
	endfunction
	always @(posedge clk) begin
		cycles++;
		if (wr_valid === 1'b1) begin
			nwr++;
			seen_wr <= wr_data;
		end
		// The next byte is popped once the port has taken the current one.
		if (rd_taken === 1'b1) rd_data <= rd_data + 8'h11;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end
	initial begin
		void'($urandom(5));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			w = 8'($urandom());
			status_enable <= i < 4;
			wr_buf_full <= w[0];
			rd_buf_empty <= w[1];
			repeat (8) @(posedge clk);
			@(negedge clk);
			check("line0", data_in[0], i < 4 ? w[0] : 1'b1);
			if (i < 4) check("miso", miso_out, w[1]);
			check("miso_oe_n", miso_oe_n, i >= 4);
			@(posedge clk);
		end
		status_enable <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			w = i < 4 ? 8'hff - 8'(i * 6) : 8'($urandom());
			c = cbyte(i[3:0], 8'($urandom()));
			mst.frame(w, c, 1'b0, 16'h0000, 0, rd, nk);
			check("bus_width", bus_width, wexp((c & 8'h69) | (w & 8'h96)));
			check("cmd_code", cmd_code, i[3:0]);
		end
		for (int j = 0; j < 4; j++) begin
			w = 8'($urandom());
			wr_buf_full <= j == 1;
			rd_buf_empty <= j == 3;
			rd_data <= w;
			nwr = 0;
			@(posedge clk);
			mst.frame(8'hff, cbyte(j[1] ? VWSP_CMD_READ_DEF : VWSP_CMD_WRITE_DEF,
				8'($urandom())), !j[1], {w + 8'h11, w}, 2, rd, nk);
			@(negedge clk);
			check("nak", nk, j[0] ? 2'b01 : 2'b00);
			if (!j[1]) check("wr_count", 16'(nwr), j == 0 ? 16'd2 : 16'd0);
			if (j == 0) check("wr_data", seen_wr, w + 8'h11);
			if (j == 2) check("rd_bytes", rd, {w + 8'h11, w});
			check("status", {miso_oe_n, data_oe_n[0], data_in[0]},
				{2'b00, j == 1});
			@(posedge clk);
		end
		results();
	end
endmodule
`default_nettype wire
